// file: include/cpu_exc_pkg.sv
/*
 Constants and carrier types of the status and exception unit.
 Assumes one core clock; all pipeline signals are on that clock.
*/
package cpu_exc_pkg;
	localparam int          WORD_W   = 32;
	localparam int          POS_N    = 31;
	localparam int          POS_Z    = 30;
	localparam int          POS_C    = 29;
	localparam int          POS_V    = 28;
	localparam int          POS_Q    = 27;
	localparam int          POS_J    = 24;
	localparam int          POS_I    = 7;
	localparam int          POS_F    = 6;
	localparam int          POS_T    = 5;
	localparam int          COND_HI  = 31;
	localparam int          COND_LO  = 28;
	localparam logic [4:0]  MODE_USR = 5'h10;
	localparam logic [4:0]  MODE_FIQ = 5'h11;
	localparam logic [4:0]  MODE_IRQ = 5'h12;
	localparam logic [4:0]  MODE_SVC = 5'h13;
	localparam logic [4:0]  MODE_ABT = 5'h17;
	localparam logic [4:0]  MODE_UND = 5'h1b;
	localparam logic [4:0]  MODE_SYS = 5'h1f;
	localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
	localparam logic [31:0] VECTOR_BASE  = 32'h0000_0000;
	localparam logic [31:0] USER_MASK    = 32'hff00_0000;
	localparam logic [7:0]  REG_STATUS = 8'h00;
	localparam logic [7:0]  REG_SAVED  = 8'h04;
	localparam logic [7:0]  REG_LINK   = 8'h08;
	localparam logic [7:0]  REG_STACK  = 8'h0c;
	localparam logic [7:0]  REG_CAUSE  = 8'h10;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [3:0]  IDX_R8  = 4'h8;
	localparam logic [3:0]  IDX_R12 = 4'hc;
	localparam logic [3:0]  IDX_R13 = 4'hd;
	localparam logic [3:0]  IDX_R14 = 4'he;
	localparam int          BANKS   = 6;
	localparam int          SAVED_N = 5;
	localparam int          HI_N    = 5;

	// Vector address is the cause code times four
	typedef enum logic [2:0] {
		CAUSE_RESET = 3'h0, CAUSE_UND = 3'h1, CAUSE_SWI = 3'h2,
		CAUSE_PABT = 3'h3, CAUSE_DABT = 3'h4, CAUSE_IRQ = 3'h6,
		CAUSE_FIQ = 3'h7
	} cause_type;
	typedef enum logic [2:0] {
		ST_BOOT = 3'b001, ST_RUN = 3'b010, ST_ENTER = 3'b100
	} fsm_type;
	typedef enum logic [1:0] {
		XS_FULL = 2'h0, XS_COMP = 2'h1, XS_BYTE = 2'h2
	} exec_state_type;
	typedef struct packed {
		logic       upd;
		logic [3:0] nzcv;
		logic       sat;
	} alu_update_type;
	typedef struct packed {
		logic        en;
		logic        toSaved;
		logic [3:0]  byteMask;
		logic [31:0] data;
	} status_write_type;
	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic        undef;
		logic        swTrap;
	} exec_event_type;
	typedef struct packed {
		logic advance;
		logic flush;
		logic fetchAbort;
		logic decBkpt;
	} pipe_ctl_type;
endpackage

// file: verilog/cpu_status_exc.sv
/*
 Status word, saved words, banked registers, exception arbitration,
 entry and return of the core. Software sees the state over AHB-Lite.
 Assumes pipeline inputs on clk; interrupt lines are asynchronous.
*/
`timescale 1ns/1ps
module cpu_status_exc #(
	parameter int DATA_W = 32
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	input  wire logic                          fastIrqPin,
	input  wire logic                          normIrqPin,
	input  wire logic                          dataAbort,
	input  wire cpu_exc_pkg::alu_update_type   alu,
	input  wire cpu_exc_pkg::status_write_type swr,
	input  wire cpu_exc_pkg::exec_event_type   exEvt,
	input  wire cpu_exc_pkg::pipe_ctl_type     pipe,
	input  wire logic [31:0]                   curPc,
	input  wire logic                          retReq,
	input  wire logic                          rWrEn,
	input  wire logic [3:0]                    rWrIdx,
	input  wire logic [31:0]                   rWrData,
	input  wire logic [3:0]                    rRdIdx,
	output logic [31:0]                        rRdData,
	output logic [31:0]                        statusWord,
	output cpu_exc_pkg::exec_state_type        execState,
	output logic                               execGo,
	output logic                               fetchRedirect,
	output logic [31:0]                        fetchAddr,
	output cpu_exc_pkg::cause_type             lastCause
);
	if (DATA_W != cpu_exc_pkg::WORD_W) begin : g_chk
		$error("DATA_W must be 32");
	end

	function automatic logic condHolds(input logic [3:0] c,
		input logic [3:0] f);
		logic n, z, cy, v;
		{n, z, cy, v} = f;
		case (c)
			4'h0: condHolds = z;
			4'h1: condHolds = !z;
			4'h2: condHolds = cy;
			4'h3: condHolds = !cy;
			4'h4: condHolds = n;
			4'h5: condHolds = !n;
			4'h6: condHolds = v;
			4'h7: condHolds = !v;
			4'h8: condHolds = cy && !z;
			4'h9: condHolds = !cy || z;
			4'ha: condHolds = n == v;
			4'hb: condHolds = n != v;
			4'hc: condHolds = !z && (n == v);
			4'hd: condHolds = z || (n != v);
			default: condHolds = 1'b1;
		endcase
	endfunction

	function automatic logic [2:0] bankOf(input logic [4:0] m);
		case (m)
			cpu_exc_pkg::MODE_FIQ: bankOf = 3'h1;
			cpu_exc_pkg::MODE_IRQ: bankOf = 3'h2;
			cpu_exc_pkg::MODE_SVC: bankOf = 3'h3;
			cpu_exc_pkg::MODE_ABT: bankOf = 3'h4;
			cpu_exc_pkg::MODE_UND: bankOf = 3'h5;
			default:               bankOf = 3'h0;
		endcase
	endfunction

	function automatic logic [4:0] modeOf(input cpu_exc_pkg::cause_type k);
		case (k)
			cpu_exc_pkg::CAUSE_FIQ:  modeOf = cpu_exc_pkg::MODE_FIQ;
			cpu_exc_pkg::CAUSE_IRQ:  modeOf = cpu_exc_pkg::MODE_IRQ;
			cpu_exc_pkg::CAUSE_PABT,
			cpu_exc_pkg::CAUSE_DABT: modeOf = cpu_exc_pkg::MODE_ABT;
			cpu_exc_pkg::CAUSE_UND:  modeOf = cpu_exc_pkg::MODE_UND;
			default:                 modeOf = cpu_exc_pkg::MODE_SVC;
		endcase
	endfunction

	// Link offset: data abort +8; compressed trap/undefined +2; else +4
	function automatic logic [31:0] linkOff(input cpu_exc_pkg::cause_type k,
		input logic comp);
		if (k == cpu_exc_pkg::CAUSE_DABT)
			linkOff = 32'h8;
		else if (comp && (k == cpu_exc_pkg::CAUSE_SWI ||
			k == cpu_exc_pkg::CAUSE_UND))
			linkOff = 32'h2;
		else
			linkOff = 32'h4;
	endfunction

	function automatic logic [31:0] retOff(input cpu_exc_pkg::cause_type k);
		case (k)
			cpu_exc_pkg::CAUSE_DABT: retOff = 32'h8;
			cpu_exc_pkg::CAUSE_FIQ,
			cpu_exc_pkg::CAUSE_IRQ,
			cpu_exc_pkg::CAUSE_PABT: retOff = 32'h4;
			default:                 retOff = 32'h0;
		endcase
	endfunction

	cpu_exc_pkg::fsm_type   state;
	cpu_exc_pkg::cause_type pendCause;
	cpu_exc_pkg::cause_type excCause;
	cpu_exc_pkg::cause_type slotCause [cpu_exc_pkg::SAVED_N];
	logic [31:0] savedWord [cpu_exc_pkg::SAVED_N];
	logic [31:0] stackReg  [cpu_exc_pkg::BANKS];
	logic [31:0] linkReg   [cpu_exc_pkg::BANKS];
	logic [31:0] hiUsr     [cpu_exc_pkg::HI_N];
	logic [31:0] hiFiq     [cpu_exc_pkg::HI_N];
	logic [1:0]  fiqSync;
	logic [1:0]  irqSync;
	logic        decAbort;
	logic        exAbort;
	logic        exBkpt;
	logic [31:0] pendLink;
	logic        aWr;
	logic [7:0]  aAddr;
	logic [31:0] next_status;
	logic [4:0]  mode;
	logic [2:0]  bank;
	logic [2:0]  slot;
	logic [2:0]  pendSlot;
	logic        priv;
	logic        condOk;
	logic        fiqReq;
	logic        irqReq;
	logic        pabtReq;
	logic        bkptReq;
	logic        undReq;
	logic        swiReq;
	logic        anyExc;
	logic        take;
	logic        retGo;
	logic        ahbRd;
	logic [31:0] rdMux;

	assign mode     = statusWord[4:0];
	assign bank     = bankOf(mode);
	assign slot     = bank - 3'h1;
	assign pendSlot = bankOf(modeOf(pendCause)) - 3'h1;
	assign priv     = bank != 3'h0;
	assign condOk   = condHolds(exEvt.instr[cpu_exc_pkg::COND_HI:
		cpu_exc_pkg::COND_LO], statusWord[31:28]);

	// Interrupt lines come from outside the clock domain
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fiqSync <= 2'h0;
			irqSync <= 2'h0;
		end else begin
			fiqSync <= {fiqSync[0], fastIrqPin};
			irqSync <= {irqSync[0], normIrqPin};
		end
	end

	// Abort and breakpoint marks ride with the instruction
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			decAbort <= 1'b0;
			exAbort  <= 1'b0;
			exBkpt   <= 1'b0;
		end else if (pipe.flush || take) begin
			decAbort <= 1'b0;
			exAbort  <= 1'b0;
			exBkpt   <= 1'b0;
		end else if (pipe.advance) begin
			decAbort <= pipe.fetchAbort;
			exAbort  <= decAbort;
			exBkpt   <= pipe.decBkpt;
		end
	end

	assign fiqReq  = fiqSync[1] && !statusWord[cpu_exc_pkg::POS_F];
	assign irqReq  = irqSync[1] && !statusWord[cpu_exc_pkg::POS_I];
	assign pabtReq = exEvt.valid && exAbort;
	assign bkptReq = exEvt.valid && exBkpt;
	assign undReq  = exEvt.valid && condOk && exEvt.undef && !exBkpt;
	assign swiReq  = exEvt.valid && condOk && exEvt.swTrap && !exBkpt &&
		!exEvt.undef;
	assign anyExc  = dataAbort || fiqReq || irqReq || pabtReq ||
		bkptReq || undReq || swiReq;
	assign take    = (state == cpu_exc_pkg::ST_RUN) && anyExc;
	assign retGo   = (state == cpu_exc_pkg::ST_RUN) && !anyExc && retReq &&
		priv && mode != cpu_exc_pkg::MODE_SYS;

	always_comb begin
		if (dataAbort)
			excCause = cpu_exc_pkg::CAUSE_DABT;
		else if (fiqReq)
			excCause = cpu_exc_pkg::CAUSE_FIQ;
		else if (irqReq)
			excCause = cpu_exc_pkg::CAUSE_IRQ;
		else if (pabtReq || bkptReq)
			excCause = cpu_exc_pkg::CAUSE_PABT;
		else if (undReq)
			excCause = cpu_exc_pkg::CAUSE_UND;
		else
			excCause = cpu_exc_pkg::CAUSE_SWI;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= cpu_exc_pkg::ST_BOOT;
			pendCause <= cpu_exc_pkg::CAUSE_RESET;
			pendLink  <= 32'h0;
		end else begin
			case (state)
				cpu_exc_pkg::ST_BOOT: state <= cpu_exc_pkg::ST_RUN;
				cpu_exc_pkg::ST_RUN: begin
					if (take) begin
						state     <= cpu_exc_pkg::ST_ENTER;
						pendCause <= excCause;
						pendLink  <= curPc + linkOff(excCause,
							statusWord[cpu_exc_pkg::POS_T]);
					end
				end
				cpu_exc_pkg::ST_ENTER: state <= cpu_exc_pkg::ST_RUN;
				default: state <= cpu_exc_pkg::ST_RUN;
			endcase
		end
	end

	// Current status word: entry, return, bus, status write, ALU
	always_comb begin
		next_status = statusWord;
		if (state == cpu_exc_pkg::ST_ENTER) begin
			next_status[4:0] = modeOf(pendCause);
			next_status[cpu_exc_pkg::POS_I] = 1'b1;
			next_status[cpu_exc_pkg::POS_T] = 1'b0;
			next_status[cpu_exc_pkg::POS_J] = 1'b0;
			if (pendCause == cpu_exc_pkg::CAUSE_FIQ)
				next_status[cpu_exc_pkg::POS_F] = 1'b1;
		end else if (retGo) begin
			next_status = savedWord[slot];
		end else if (aWr && aAddr == cpu_exc_pkg::REG_STATUS) begin
			next_status = hwdata;
		end else begin
			if (swr.en && !swr.toSaved)
				for (int b = 0; b < 4; b++)
					if (swr.byteMask[b] && (priv || b == 3))
						next_status[8*b +: 8] = swr.data[8*b +: 8];
			if (alu.upd)
				next_status[31:28] = alu.nzcv;
		end
		if (alu.sat)
			next_status[cpu_exc_pkg::POS_Q] = 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			statusWord <= cpu_exc_pkg::STATUS_RESET;
		else
			statusWord <= next_status;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			execState <= cpu_exc_pkg::XS_FULL;
		else if (next_status[cpu_exc_pkg::POS_J])
			execState <= cpu_exc_pkg::XS_BYTE;
		else if (next_status[cpu_exc_pkg::POS_T])
			execState <= cpu_exc_pkg::XS_COMP;
		else
			execState <= cpu_exc_pkg::XS_FULL;
	end

	// Saved words: one per exception mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < cpu_exc_pkg::SAVED_N; i++) begin
				savedWord[i] <= 32'h0;
				slotCause[i] <= cpu_exc_pkg::CAUSE_RESET;
			end
		end else if (state == cpu_exc_pkg::ST_ENTER) begin
			savedWord[pendSlot] <= statusWord;
			slotCause[pendSlot] <= pendCause;
		end else if (priv && mode != cpu_exc_pkg::MODE_SYS) begin
			if (aWr && aAddr == cpu_exc_pkg::REG_SAVED)
				savedWord[slot] <= hwdata;
			else if (swr.en && swr.toSaved)
				for (int b = 0; b < 4; b++)
					if (swr.byteMask[b])
						savedWord[slot][8*b +: 8] <= swr.data[8*b +: 8];
		end
	end

	// Banked stack pointers and links
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < cpu_exc_pkg::BANKS; i++) begin
				stackReg[i] <= 32'h0;
				linkReg[i]  <= 32'h0;
			end
		end else begin
			if (state == cpu_exc_pkg::ST_ENTER)
				linkReg[pendSlot + 3'h1] <= pendLink;
			else if (rWrEn && rWrIdx == cpu_exc_pkg::IDX_R14)
				linkReg[bank] <= rWrData;
			if (aWr && aAddr == cpu_exc_pkg::REG_STACK)
				stackReg[bank] <= hwdata;
			else if (rWrEn && rWrIdx == cpu_exc_pkg::IDX_R13)
				stackReg[bank] <= rWrData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < cpu_exc_pkg::HI_N; i++) begin
				hiUsr[i] <= 32'h0;
				hiFiq[i] <= 32'h0;
			end
		end else if (rWrEn && rWrIdx >= cpu_exc_pkg::IDX_R8 &&
			rWrIdx <= cpu_exc_pkg::IDX_R12) begin
			if (mode == cpu_exc_pkg::MODE_FIQ)
				hiFiq[3'(rWrIdx - cpu_exc_pkg::IDX_R8)] <= rWrData;
			else
				hiUsr[3'(rWrIdx - cpu_exc_pkg::IDX_R8)] <= rWrData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rRdData <= 32'h0;
		else if (rRdIdx == cpu_exc_pkg::IDX_R13)
			rRdData <= stackReg[bank];
		else if (rRdIdx == cpu_exc_pkg::IDX_R14)
			rRdData <= linkReg[bank];
		else if (rRdIdx >= cpu_exc_pkg::IDX_R8 &&
			rRdIdx <= cpu_exc_pkg::IDX_R12)
			rRdData <= (mode == cpu_exc_pkg::MODE_FIQ) ?
				hiFiq[3'(rRdIdx - cpu_exc_pkg::IDX_R8)] :
				hiUsr[3'(rRdIdx - cpu_exc_pkg::IDX_R8)];
		else
			rRdData <= 32'h0;
	end

	// Fetch redirect, execute gate, cause
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetchRedirect <= 1'b0;
			fetchAddr     <= 32'h0;
			execGo        <= 1'b0;
			lastCause     <= cpu_exc_pkg::CAUSE_RESET;
		end else begin
			fetchRedirect <= (state != cpu_exc_pkg::ST_RUN) || retGo;
			if (state != cpu_exc_pkg::ST_RUN) begin
				fetchAddr <= cpu_exc_pkg::VECTOR_BASE |
					{27'h0, pendCause, 2'h0};
				lastCause <= pendCause;
			end else if (retGo)
				fetchAddr <= linkReg[bank] - retOff(slotCause[slot]);
			execGo <= exEvt.valid && condOk && !anyExc &&
				(state == cpu_exc_pkg::ST_RUN);
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	assign ahbRd = hsel && hready && htrans == cpu_exc_pkg::HTRANS_NONSEQ &&
		!hwrite;
	always_comb begin
		case (haddr[7:0])
			cpu_exc_pkg::REG_STATUS: rdMux = statusWord;
			cpu_exc_pkg::REG_SAVED:
				rdMux = (priv && mode != cpu_exc_pkg::MODE_SYS) ?
					savedWord[slot] : 32'h0;
			cpu_exc_pkg::REG_LINK:   rdMux = linkReg[bank];
			cpu_exc_pkg::REG_STACK:  rdMux = stackReg[bank];
			cpu_exc_pkg::REG_CAUSE:  rdMux = {29'h0, lastCause};
			default:                 rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aWr       <= 1'b0;
			aAddr     <= 8'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			aWr   <= hsel && hready && hwrite &&
				htrans == cpu_exc_pkg::HTRANS_NONSEQ;
			aAddr <= haddr[7:0];
			hrdata <= ahbRd ? rdMux : 32'h0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_take;
		state == cpu_exc_pkg::ST_RUN && anyExc;
	endsequence
	sequence s_enter;
		state == cpu_exc_pkg::ST_ENTER;
	endsequence

	a_entry_vector: assert property (
		s_take ##1 s_enter |=> fetchRedirect &&
		fetchAddr == {27'h0, $past(pendCause), 2'h0})
		else $error("vector fetch wrong after entry");
	a_entry_mode: assert property (
		s_take |-> ##2 statusWord[4:0] == modeOf($past(excCause, 2)))
		else $error("mode not forced on entry");
	a_entry_save: assert property (
		s_enter |=> savedWord[$past(pendSlot)] == $past(statusWord))
		else $error("status not saved on entry");
	a_sat_wins: assert property (
		alu.sat |=> statusWord[cpu_exc_pkg::POS_Q])
		else $error("saturation set lost");
	a_sat_sticky: assert property (
		statusWord[cpu_exc_pkg::POS_Q] && !swr.en && !aWr && !retGo |=>
		statusWord[cpu_exc_pkg::POS_Q])
		else $error("saturation flag dropped");
	a_abort_first: assert property (
		s_take and dataAbort |=> pendCause == cpu_exc_pkg::CAUSE_DABT)
		else $error("data abort not first");
	a_abort_fast: assert property (
		s_enter and pendCause == cpu_exc_pkg::CAUSE_DABT and
		!statusWord[cpu_exc_pkg::POS_F] |=>
		!statusWord[cpu_exc_pkg::POS_F] && statusWord[cpu_exc_pkg::POS_I])
		else $error("abort entry blocks fast interrupt");
	a_trap_excl: assert property (
		$onehot0({bkptReq, undReq, swiReq}))
		else $error("two exclusive exceptions raised");
	a_flush_drop: assert property (
		pipe.flush |=> !exAbort && !exBkpt)
		else $error("flushed abort mark kept");
	a_cond_gate: assert property (
		execGo |-> $past(condOk) && $past(exEvt.valid))
		else $error("execute without condition");
	a_byte_state: assert property (
		statusWord[cpu_exc_pkg::POS_J] |-> execState == cpu_exc_pkg::XS_BYTE)
		else $error("bytecode state not shown");
endmodule // cpu_status_exc

// file: verif/irq_source_model.sv
/*
 Interrupt sources beside the core: fast and normal request lines.
 Assumes a line is held until the core enters the handler for it.
*/
`timescale 1ns/1ps
module irq_source_model (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   fastReq,
	input  wire logic                   normReq,
	input  wire logic                   entered,
	input  wire cpu_exc_pkg::cause_type cause,
	output logic                        fastIrqPin,
	output logic                        normIrqPin
);
	// Level request, dropped once the handler is entered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fastIrqPin <= 1'b0;
			normIrqPin <= 1'b0;
		end else begin
			if (fastReq)
				fastIrqPin <= 1'b1;
			else if (entered && cause == cpu_exc_pkg::CAUSE_FIQ)
				fastIrqPin <= 1'b0;
			if (normReq)
				normIrqPin <= 1'b1;
			else if (entered && cause == cpu_exc_pkg::CAUSE_IRQ)
				normIrqPin <= 1'b0;
		end
	end
endmodule // irq_source_model

// file: verif/cpu_status_and_exception_unit_bench.sv
/*
 Self-checking bench of the status and exception unit.
 Assumes the bench plays bus master and pipeline; a model raises irqs.
*/
`timescale 1ns/1ps
module cpu_status_and_exception_unit_bench;
	localparam logic [31:0] A_ST = 32'(cpu_exc_pkg::REG_STATUS);
	localparam logic [31:0] A_SV = 32'(cpu_exc_pkg::REG_SAVED);
	localparam logic [31:0] A_LK = 32'(cpu_exc_pkg::REG_LINK);
	localparam logic [31:0] A_CS = 32'(cpu_exc_pkg::REG_CAUSE);
	logic        clk, sys_rst, hsel, hwrite, dataAbort, retReq, rWrEn;
	logic        fastReq, normReq, fastIrqPin, normIrqPin, hreadyout;
	logic        execGo, fetchRedirect, hresp, s;
	logic [1:0]  htrans;
	logic [3:0]  rWrIdx, rRdIdx, f, c;
	logic [31:0] haddr, hwdata, hrdata, curPc, statusWord, fetchAddr;
	logic [31:0] rWrData, rRdData, st, old, mid, pc, r;
	logic [31:0] expQ[$];
	logic [31:0] wrTab[5] = '{32'h13, 32'h33, 32'h0100_0013,
		32'h0100_0033, 32'h13};
	logic [31:0] xsTab[5] = '{32'h0, 32'h1, 32'h2, 32'h2, 32'h0};
	int          fails, check_count, cyc, seed;
	cpu_exc_pkg::alu_update_type   alu;
	cpu_exc_pkg::status_write_type swr;
	cpu_exc_pkg::exec_event_type   exEvt;
	cpu_exc_pkg::pipe_ctl_type     pipe;
	cpu_exc_pkg::exec_state_type   execState;
	cpu_exc_pkg::cause_type        lastCause;

	cpu_status_exc cpu_status_exc_inst (.clk(clk), .sys_rst(sys_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.fastIrqPin(fastIrqPin), .normIrqPin(normIrqPin),
		.dataAbort(dataAbort), .alu(alu), .swr(swr), .exEvt(exEvt),
		.pipe(pipe), .curPc(curPc), .retReq(retReq), .rWrEn(rWrEn),
		.rWrIdx(rWrIdx), .rWrData(rWrData), .rRdIdx(rRdIdx),
		.rRdData(rRdData), .statusWord(statusWord), .execState(execState),
		.execGo(execGo), .fetchRedirect(fetchRedirect),
		.fetchAddr(fetchAddr), .lastCause(lastCause));
	irq_source_model irq_source_model_inst (.clk(clk), .sys_rst(sys_rst),
		.fastReq(fastReq), .normReq(normReq), .entered(fetchRedirect),
		.cause(lastCause), .fastIrqPin(fastIrqPin),
		.normIrqPin(normIrqPin));

	always #12.5 clk = ~clk;

	task automatic chk(input logic [31:0] got, exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= cpu_exc_pkg::HTRANS_NONSEQ;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		q = hrdata;
		chk(32'(hresp), 32'h0, "bus response");
	endtask
	task automatic regW(input logic [3:0] i, input logic [31:0] v);
		@(posedge clk);
		rWrEn <= 1'b1;
		rWrIdx <= i;
		rWrData <= v;
		@(posedge clk);
		rWrEn <= 1'b0;
	endtask
	task automatic regR(input logic [3:0] i, output logic [31:0] q);
		@(posedge clk);
		rRdIdx <= i;
		repeat (2) @(posedge clk);
		@(negedge clk);
		q = rRdData;
	endtask
	task automatic waitQ;
		repeat (40) if (expQ.size() != 0) @(negedge clk);
		chk(32'(expQ.size()), 32'h0, "entries seen");
	endtask
	task automatic ret(input logic [31:0] a);
		@(posedge clk);
		retReq <= 1'b1;
		@(posedge clk);
		retReq <= 1'b0;
		expQ.push_back(a);
		waitQ;
	endtask
	function automatic logic condOk(input logic [3:0] c, f);
		logic b;
		case (c[3:1])
			3'h0: b = f[2];
			3'h1: b = f[1];
			3'h2: b = f[3];
			3'h3: b = f[0];
			3'h4: b = f[1] & !f[2];
			3'h5: b = f[3] == f[0];
			3'h6: b = !f[2] & (f[3] == f[0]);
			default: b = 1'b1;
		endcase
		return (c[0] && c != 4'he) ? !b : b;
	endfunction
	// Expected status after entry: T, J cleared, I set, F for fast
	function automatic logic [31:0] ent(input logic [31:0] x,
		input logic [4:0] m);
		return (x & 32'hfeff_ffc0) | 32'h80 | 32'(m) |
			(m == cpu_exc_pkg::MODE_FIQ ? 32'h40 : 32'h0);
	endfunction

	always @(negedge clk)
		if (fetchRedirect === 1'b1) begin
			if (expQ.size() == 0)
				chk(fetchAddr, 32'hffff_ffff, "stray redirect");
			else
				chk(fetchAddr, expQ.pop_front(), "vector");
		end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end

	initial begin
		{clk, hsel, hwrite, dataAbort, retReq, rWrEn} = '0;
		{fastReq, normReq, htrans, rWrIdx, rRdIdx} = '0;
		{haddr, hwdata, curPc, rWrData, alu, swr, exEvt} = '0;
		pipe = 4'h8;
		sys_rst = 1'b1;
		{fails, check_count, cyc} = '0;
		seed = 32'h1b6f;
		st = cpu_exc_pkg::STATUS_RESET;
		expQ.push_back(cpu_exc_pkg::VECTOR_BASE);
		repeat (20) @(posedge clk);
		chk(statusWord, st, "reset status");
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		bus(1'b0, A_ST, 32'h0, r);
		chk(r, st, "status read");
		foreach (wrTab[i]) begin
			bus(1'b1, A_ST, wrTab[i], r);
			@(negedge clk);
			chk(statusWord, wrTab[i], "mode write");
			chk(32'(execState), xsTab[i], "exec state");
		end
		st = 32'h13;
		$display("test modes done");
		repeat (30) begin
			{f, s} = 5'($random(seed));
			c = 4'($unsigned($random(seed)) % 15);
			@(posedge clk);
			alu <= '{1'b1, f, s};
			@(posedge clk);
			alu <= '0;
			exEvt <= '{1'b1, {c, 28'($random(seed))}, 1'b0, 1'b0};
			@(posedge clk);
			exEvt <= '0;
			@(negedge clk);
			st = {f, st[27] | s, st[26:0]};
			chk(statusWord, st, "flags");
			chk(32'(execGo), 32'(condOk(c, f)), "cond");
		end
		@(posedge clk);
		alu <= '{1'b1, 4'h0, 1'b1};
		@(posedge clk);
		alu <= '{1'b1, 4'h0, 1'b0};
		@(posedge clk);
		alu <= '0;
		swr <= '{1'b1, 1'b0, 4'h8, 32'h0};
		@(negedge clk);
		chk(32'(statusWord[27:24]), 32'h8, "sticky held");
		@(posedge clk);
		swr <= '0;
		@(negedge clk);
		st = 32'h13;
		chk(statusWord, st, "sticky cleared");
		$display("test flags done");
		regW(4'hd, 32'h5a5a_0013);
		regW(4'h8, 32'h0808_0808);
		pc = 32'($random(seed)) & 32'hffff_fffc;
		old = st;
		@(posedge clk);
		curPc <= pc;
		dataAbort <= 1'b1;
		@(posedge clk);
		dataAbort <= 1'b0;
		expQ.push_back(32'h10);
		waitQ;
		st = ent(old, cpu_exc_pkg::MODE_ABT);
		chk(statusWord, st, "abort entry");
		bus(1'b0, A_LK, 32'h0, r);
		chk(r, pc + 32'h8, "abort link");
		bus(1'b0, A_SV, 32'h0, r);
		chk(r, old, "abort saved");
		regW(4'hd, 32'ha5a5_0017);
		ret(pc);
		chk(statusWord, old, "abort return");
		regR(4'hd, r);
		chk(r, 32'h5a5a_0013, "own stack");
		$display("test abort done");
		@(posedge clk);
		dataAbort <= 1'b1;
		fastReq <= 1'b1;
		@(posedge clk);
		dataAbort <= 1'b0;
		fastReq <= 1'b0;
		expQ.push_back(32'h10);
		expQ.push_back(32'h1c);
		waitQ;
		mid = ent(old, cpu_exc_pkg::MODE_ABT);
		st = ent(mid, cpu_exc_pkg::MODE_FIQ);
		chk(statusWord, st, "fast after abort");
		bus(1'b0, A_SV, 32'h0, r);
		chk(r, mid, "fast saved");
		bus(1'b0, A_LK, 32'h0, r);
		chk(r, pc + 32'h4, "fast link");
		regW(4'h8, 32'hf1f1_0008);
		ret(pc);
		chk(statusWord, mid, "back to abort");
		ret(pc);
		chk(statusWord, old, "back to start");
		regR(4'h8, r);
		chk(r, 32'h0808_0808, "fast bank");
		$display("test nesting done");
		@(posedge clk);
		normReq <= 1'b1;
		@(posedge clk);
		normReq <= 1'b0;
		expQ.push_back(32'h18);
		waitQ;
		chk(statusWord, ent(old, cpu_exc_pkg::MODE_IRQ), "irq");
		bus(1'b0, A_LK, 32'h0, r);
		chk(r, pc + 32'h4, "irq link");
		bus(1'b0, A_CS, 32'h0, r);
		chk(r, 32'(cpu_exc_pkg::CAUSE_IRQ), "irq cause");
		ret(pc);
		chk(statusWord, old, "irq return");
		$display("test irq done");
		// Compressed state; undefined and trap raised together
		bus(1'b1, A_ST, 32'h33, r);
		@(posedge clk);
		exEvt <= '{1'b1, 32'he000_0000, 1'b1, 1'b1};
		@(posedge clk);
		exEvt <= '0;
		expQ.push_back(32'h4);
		waitQ;
		chk(statusWord, ent(32'h33, cpu_exc_pkg::MODE_UND), "und");
		bus(1'b0, A_LK, 32'h0, r);
		chk(r, pc + 32'h2, "compressed link");
		ret(pc + 32'h2);
		chk(statusWord, 32'h33, "und return");
		chk(32'(execState), 32'h1, "compressed back");
		$display("test undefined done");
		// Abort mark flushed before execute: nothing taken
		@(posedge clk);
		pipe <= 4'ha;
		@(posedge clk);
		pipe <= 4'hc;
		@(posedge clk);
		pipe <= 4'h8;
		exEvt <= '{1'b1, 32'he000_0000, 1'b0, 1'b0};
		@(posedge clk);
		exEvt <= '0;
		@(negedge clk);
		chk(32'(execGo), 32'h1, "flushed abort");
		// Breakpoint reaches execute and is taken
		@(posedge clk);
		pipe <= 4'h9;
		@(posedge clk);
		pipe <= 4'h8;
		exEvt <= '{1'b1, 32'he000_0000, 1'b0, 1'b0};
		@(posedge clk);
		exEvt <= '0;
		expQ.push_back(32'hc);
		waitQ;
		chk(statusWord, ent(32'h33, cpu_exc_pkg::MODE_ABT), "breakpoint_instruction");
		bus(1'b0, A_LK, 32'h0, r);
		chk(r, pc + 32'h4, "breakpoint_instruction link");
		ret(pc);
		chk(statusWord, 32'h33, "breakpoint_instruction return");
		$display("test breakpoint done");
		give_verdict;
	end
endmodule // cpu_status_and_exception_unit_bench
